/* File: ptc_top.sv */
/*
  periodic tick counter: apb register file, prescaler, 8-bit tick counter
  with match limit, periodic flag and interrupt.
  assumes apb master on pclk; debug_halt and the mode inputs come from pclk logic.
*/
`timescale 1ns/1ps
module ptc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_power_osc_clock,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire logic wait_mode,
  input wire logic deep_stop_mode,
  input wire logic shallow_stop_mode,
  input wire logic debug_halt,
  output logic irq
);

  ptc_pkg::ptc_ctrl_s ctrl_q;
  ptc_pkg::ptc_ctrl_s ctrl_d;
  logic [7:0] limit_q;
  logic [7:0] limit_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [ptc_pkg::PRESC_W-1:0] presc_q;
  logic [ptc_pkg::PRESC_W-1:0] presc_d;
  logic [ptc_pkg::EVT_W-1:0] evt_q;
  logic [ptc_pkg::EVT_W-1:0] evt_d;
  logic [ptc_pkg::EVT_W-1:0] mask_q;
  logic [ptc_pkg::EVT_W-1:0] mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic src_edge;
  logic wr;
  logic rd;
  logic mapped;
  logic wr_ctrl;
  logic wr_limit;
  logic reconf;
  logic run;
  logic presc_out;
  logic match_evt;
  logic [ptc_pkg::PRESC_W-1:0] div;

  // prescaler divide ratio from source bit 0 and divider code
  function automatic logic [ptc_pkg::PRESC_W-1:0] div_of(input logic hi, input logic [3:0] ps);
    logic [ptc_pkg::PRESC_W-1:0] r;
    r = 18'h0_0001;
    if (!hi)
    begin
      case (ps)
        4'h1: r = 18'h0_0008;
        4'h2: r = 18'h0_0020;
        4'h3: r = 18'h0_0040;
        4'h4: r = 18'h0_0080;
        4'h5: r = 18'h0_0100;
        4'h6: r = 18'h0_0200;
        4'h7: r = 18'h0_0400;
        4'h8: r = 18'h0_0001;
        4'h9: r = 18'h0_0002;
        4'ha: r = 18'h0_0004;
        4'hb: r = 18'h0_000a;
        4'hc: r = 18'h0_0010;
        4'hd: r = 18'h0_0064;
        4'he: r = 18'h0_01f4;
        4'hf: r = 18'h0_03e8;
        default: r = 18'h0_0001;
      endcase
    end
    else
    begin
      case (ps)
        4'h1: r = 18'h0_0400;
        4'h2: r = 18'h0_0800;
        4'h3: r = 18'h0_1000;
        4'h4: r = 18'h0_2000;
        4'h5: r = 18'h0_4000;
        4'h6: r = 18'h0_8000;
        4'h7: r = 18'h1_0000;
        4'h8: r = 18'h0_03e8;
        4'h9: r = 18'h0_07d0;
        4'ha: r = 18'h0_1388;
        4'hb: r = 18'h0_2710;
        4'hc: r = 18'h0_4e20;
        4'hd: r = 18'h0_c350;
        4'he: r = 18'h1_86a0;
        4'hf: r = 18'h3_0d40;
        default: r = 18'h0_0001;
      endcase
    end
    return r;
  endfunction

  // source selection and edge detection
  // source pick
  ptc_src_sync ptc_src_sync_inst (
    .pclk(pclk),
    .presetn(presetn),
    .low_power_osc_clock(low_power_osc_clock),
    .external_ref_clock(external_ref_clock),
    .internal_ref_clock(internal_ref_clock),
    .tick_source_select(ctrl_q.tick_source_select),
    .deep_stop_mode(deep_stop_mode),
    .src_edge(src_edge)
  );

  // apb decode; zero wait states, unmapped addresses answer with pslverr
  always_comb
  begin
    mapped = (paddr == ptc_pkg::OFF_CTRL) || (paddr == ptc_pkg::OFF_COUNT) ||
             (paddr == ptc_pkg::OFF_LIMIT) || (paddr == ptc_pkg::OFF_EVT_STAT) ||
             (paddr == ptc_pkg::OFF_EVT_MASK);
    wr = psel & penable & pwrite & mapped;
    rd = psel & penable & ~pwrite & mapped;
    wr_ctrl = wr && (paddr == ptc_pkg::OFF_CTRL);
    wr_limit = wr && (paddr == ptc_pkg::OFF_LIMIT);
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdata_q;

  assign reconf = wr_limit || (wr_ctrl &&
    ((pwdata[ptc_pkg::SRC_LSB +: 2] != ctrl_q.tick_source_select) ||
     (pwdata[ptc_pkg::DIV_LSB +: 4] != ctrl_q.divider_select)));

  // wait and shallow stop do not gate counting; deep stop blocks the reference sources, debug halt freezes
  // counts in wait
  assign run = (ctrl_q.divider_select != 4'h0) && !debug_halt;
  assign div = div_of(ctrl_q.tick_source_select[0], ctrl_q.divider_select);
  assign presc_out = run && src_edge && (presc_q == div - 18'h0_0001);
  assign match_evt = presc_out && (count_q == limit_q) && !reconf;

  // prescaler and tick counter next values
  always_comb
  begin
    presc_d = presc_q;
    count_d = count_q;
    if (reconf)
    begin
      presc_d = 18'h0_0000;
      count_d = ptc_pkg::COUNT_RST;
    end
    else if (run && src_edge)
    begin
      if (presc_out)
      begin
        presc_d = 18'h0_0000;
        if (count_q == limit_q)
          count_d = 8'h00;
        else
          count_d = count_q + 8'h01;
      end
      else
        presc_d = presc_q + 18'h0_0001;
    end
  end

  // register file next values; hardware set wins over every clear
  always_comb
  begin
    ctrl_d = ctrl_q;
    limit_d = limit_q;
    evt_d = evt_q;
    mask_d = mask_q;
    rdata_d = rdata_q;
    if (wr_ctrl)
    begin
      ctrl_d.tick_source_select = pwdata[ptc_pkg::SRC_LSB +: 2];
      ctrl_d.periodic_irq_enable = pwdata[ptc_pkg::IRQEN_BIT];
      ctrl_d.divider_select = pwdata[ptc_pkg::DIV_LSB +: 4];
      if (pwdata[ptc_pkg::FLAG_BIT])
        ctrl_d.periodic_match_flag = 1'b0;
    end
    if (wr_limit)
      limit_d = pwdata[7:0];
    if (wr && (paddr == ptc_pkg::OFF_EVT_MASK))
      mask_d = pwdata[ptc_pkg::EVT_W-1:0];
    // clear only what the setup cycle captured, so a late event is not lost
    if (rd && (paddr == ptc_pkg::OFF_EVT_STAT))
      evt_d = evt_q & ~rdata_q[ptc_pkg::EVT_W-1:0];
    if (match_evt)
    begin
      ctrl_d.periodic_match_flag = 1'b1;
      evt_d[ptc_pkg::EVT_MATCH_BIT] = 1'b1;
    end
    if (reconf)
      evt_d[ptc_pkg::EVT_RECONF_BIT] = 1'b1;
    // read data captured in the setup phase
    if (psel && !penable)
    begin
      case (paddr)
        ptc_pkg::OFF_CTRL: rdata_d = {24'h00_0000, ctrl_q};
        ptc_pkg::OFF_COUNT: rdata_d = {24'h00_0000, count_q};
        ptc_pkg::OFF_LIMIT: rdata_d = {24'h00_0000, limit_q};
        ptc_pkg::OFF_EVT_STAT: rdata_d = {30'h0000_0000, evt_q};
        ptc_pkg::OFF_EVT_MASK: rdata_d = {30'h0000_0000, mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= ptc_pkg::CTRL_RST;
      limit_q <= ptc_pkg::LIMIT_RST;
      count_q <= ptc_pkg::COUNT_RST;
      presc_q <= 18'h0_0000;
      evt_q <= ptc_pkg::EVT_RST;
      mask_q <= ptc_pkg::EVT_RST;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      limit_q <= limit_d;
      count_q <= count_d;
      presc_q <= presc_d;
      evt_q <= evt_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  // interrupt: periodic flag path plus masked sticky events; wakes from wait/stop
  // enabled flag drives irq
  assign irq = (ctrl_q.periodic_match_flag & ctrl_q.periodic_irq_enable) |
               (|(evt_q & mask_q));

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence limit_write_s;
    psel && penable && pwrite && (paddr == ptc_pkg::OFF_LIMIT);
  endsequence

  sequence tick_at_limit_s;
    presc_out && (count_q == limit_q) && !reconf;
  endsequence

  flag_on_match_a: assert property (tick_at_limit_s |=> ctrl_q.periodic_match_flag)
    else $error("flag not set on match");
  wrap_to_zero_a: assert property (tick_at_limit_s |=> count_q == 8'h00)
    else $error("count did not wrap");
  count_step_a: assert property (presc_out && !reconf && count_q != limit_q
    |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not step");
  limit_clear_a: assert property (limit_write_s |=> count_q == 8'h00 && presc_q == 18'h0_0000)
    else $error("limit write did not clear");
  src_change_a: assert property (wr_ctrl &&
    pwdata[ptc_pkg::SRC_LSB +: 2] != ctrl_q.tick_source_select |=> count_q == 8'h00)
    else $error("source change did not clear");
  flag_w1c_a: assert property (wr_ctrl && pwdata[ptc_pkg::FLAG_BIT] && !match_evt
    |=> !ctrl_q.periodic_match_flag && (!irq || (evt_q & mask_q) != '0))
    else $error("flag not cleared by write");
  irq_follow_a: assert property (ctrl_q.periodic_match_flag && ctrl_q.periodic_irq_enable
    |-> irq)
    else $error("irq missing");
  halt_freeze_a: assert property (debug_halt && !reconf [*2] |-> $stable(count_q))
    else $error("count moved in halt");
  div_off_a: assert property (ctrl_q.divider_select == 4'h0 && !reconf
    |=> count_q == $past(count_q))
    else $error("counting with prescaler off");

endmodule

/* File: ptc_pkg.sv */
/*
  package for the periodic tick counter: register offsets, field positions,
  reset values and the control register layout.
  assumes a 32-bit apb master and byte addresses on paddr.
*/
package ptc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_LIMIT = 8'h08;
  localparam logic [7:0] OFF_EVT_STAT = 8'h0c;
  localparam logic [7:0] OFF_EVT_MASK = 8'h10;

  // control register field positions
  localparam int FLAG_BIT = 7;
  localparam int SRC_LSB = 5;
  localparam int IRQEN_BIT = 4;
  localparam int DIV_LSB = 0;

  // event status bit positions
  localparam int EVT_MATCH_BIT = 0;
  localparam int EVT_RECONF_BIT = 1;
  localparam int EVT_W = 2;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [1:0] EVT_RST = 2'h0;

  // source select codes
  localparam logic [1:0] SRC_LOW_OSC = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;

  localparam int PRESC_W = 18;

  typedef struct packed {
    logic periodic_match_flag;
    logic [1:0] tick_source_select;
    logic periodic_irq_enable;
    logic [3:0] divider_select;
  } ptc_ctrl_s;

endpackage

/* File: ptc_src_sync.sv */
/*
  clock source selector: synchronises the three slow source clocks into pclk
  and gives one pulse per rising edge of the selected source, none for a reference source in deep stop.
  assumes each source runs well below half of pclk.
*/
`timescale 1ns/1ps
module ptc_src_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic low_power_osc_clock,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  input wire logic [1:0] tick_source_select,
  input wire logic deep_stop_mode,
  output logic src_edge
);

  logic [2:0] meta_q;
  logic [2:0] meta_d;
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic sel_q;
  logic sel_d;
  logic sel_lvl;

  // pick the synchronised source; reference clocks stop in deep stop
  always_comb
  begin
    meta_d = {internal_ref_clock, external_ref_clock, low_power_osc_clock};
    sync_d = meta_q;
    if (tick_source_select == ptc_pkg::SRC_LOW_OSC)
      sel_lvl = sync_q[0];
    else if (tick_source_select == ptc_pkg::SRC_EXT)
      sel_lvl = sync_q[1] & ~deep_stop_mode;
    else
      sel_lvl = sync_q[2] & ~deep_stop_mode;
    sel_d = sel_lvl;
  end

  // two-stage synchroniser plus edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      sel_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      sel_q <= sel_d;
    end
  end

  // a source switch can look like an edge; it comes the cycle after the clear and is counted
  assign src_edge = sel_lvl & ~sel_q;

endmodule

/* File: ptc_tb.sv */
/*
  self-checking bench for the periodic tick counter: apb master tasks,
  read expectations queued and compared by a monitor, irq checks.
  assumes ptc_top from ptc_pkg offsets; idle source clocks rest low.
*/
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] clks = 3'h0;
  logic wait_mode = 1'b0;
  logic deep_stop = 1'b0;
  logic shallow_stop = 1'b0;
  logic debug_halt = 1'b0;
  logic irq;
  logic [32:0] exp_q[$];
  int err_total = 0;
  int checks = 0;
  logic [31:0] v;

  // 10 MHz bus clock
  always #50 pclk = ~pclk;

  ptc_top ptc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_power_osc_clock(clks[0]),
    .external_ref_clock(clks[1]), .internal_ref_clock(clks[2]),
    .wait_mode(wait_mode), .deep_stop_mode(deep_stop), .shallow_stop_mode(shallow_stop),
    .debug_halt(debug_halt), .irq(irq)
  );

  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [32:0] e, input logic [32:0] s);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask

  // level irq looked at mid-cycle, once register updates have landed
  task automatic chk_irq(input logic e);
    @(negedge pclk);
    cmp("irq", {32'h0000_0000, e}, {32'h0000_0000, irq});
  endtask

  // apb transfer: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // one full low-high-low period of a source clock, slow against pclk
  task automatic tick(input int s, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      clks[s] <= 1'b1;
      repeat (6) @(posedge pclk);
      clks[s] <= 1'b0;
      repeat (5) @(posedge pclk);
    end
  endtask

  // read results compared at the access edge, oldest note first
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      if (exp_q.size() == 0)
        cmp("queue", 33'h0_0000_0000, 33'h1_0000_0000);
      else
        cmp("prdata", exp_q.pop_front(), {pslverr, prdata});
    end
  end

  // hang guard, far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'hf40f_5144));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ptc_pkg::OFF_CTRL, 32'h0000_0000);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0000);
    rd(ptc_pkg::OFF_LIMIT, 32'h0000_0000);
    rd(ptc_pkg::OFF_EVT_STAT, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000, 1'b1);
    chk_irq(1'b0);
    wr(ptc_pkg::OFF_LIMIT, 32'h0000_0003);
    wr(ptc_pkg::OFF_CTRL, 32'h0000_0018);
    wait_mode <= 1'b1;
    tick(0, 3);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0003);
    chk_irq(1'b0);
    tick(0, 1);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0000);
    rd(ptc_pkg::OFF_CTRL, 32'h0000_0098);
    chk_irq(1'b1);
    rd(ptc_pkg::OFF_EVT_STAT, 32'h0000_0003);
    rd(ptc_pkg::OFF_EVT_STAT, 32'h0000_0000);
    wr(ptc_pkg::OFF_CTRL, 32'h0000_0018);
    rd(ptc_pkg::OFF_CTRL, 32'h0000_0098);
    wr(ptc_pkg::OFF_CTRL, 32'h0000_0098);
    rd(ptc_pkg::OFF_CTRL, 32'h0000_0018);
    chk_irq(1'b0);
    wait_mode <= 1'b0;
    // divide by two, then by four
    wr(ptc_pkg::OFF_CTRL, 32'h0000_0009);
    tick(0, 3);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0001);
    wr(ptc_pkg::OFF_CTRL, 32'h0000_000a);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0000);
    tick(0, 2);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0000);
    tick(0, 2);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0001);
    wr(ptc_pkg::OFF_CTRL, 32'h0000_002a);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0000);
    wr(ptc_pkg::OFF_CTRL, 32'h0000_0048);
    tick(2, 2);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0002);
    debug_halt <= 1'b1;
    tick(2, 2);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0002);
    debug_halt <= 1'b0;
    tick(2, 1);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0003);
    wr(ptc_pkg::OFF_LIMIT, 32'h0000_0003);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0000);
    // stop modes: internal ref runs in shallow stop only, osc checked in deep stop
    shallow_stop <= 1'b1;
    tick(2, 1);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0001);
    shallow_stop <= 1'b0;
    deep_stop <= 1'b1;
    tick(2, 1);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0001);
    wr(ptc_pkg::OFF_CTRL, 32'h0000_0008);
    tick(0, 2);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0002);
    deep_stop <= 1'b0;
    wr(ptc_pkg::OFF_CTRL, 32'h0000_0040);
    tick(2, 2);
    rd(ptc_pkg::OFF_COUNT, 32'h0000_0000);
    // limit zero: flag on every pulse, irq through the event mask
    wr(ptc_pkg::OFF_LIMIT, 32'h0000_0000);
    wr(ptc_pkg::OFF_CTRL, 32'h0000_0008);
    rd(ptc_pkg::OFF_EVT_STAT, 32'h0000_0002);
    wr(ptc_pkg::OFF_EVT_MASK, 32'h0000_0001);
    chk_irq(1'b0);
    tick(0, 1);
    rd(ptc_pkg::OFF_CTRL, 32'h0000_0088);
    chk_irq(1'b1);
    rd(ptc_pkg::OFF_EVT_STAT, 32'h0000_0001);
    chk_irq(1'b0);
    wr(ptc_pkg::OFF_CTRL, 32'h0000_0088);
    rd(ptc_pkg::OFF_CTRL, 32'h0000_0008);
    tick(0, 1);
    rd(ptc_pkg::OFF_CTRL, 32'h0000_0088);
    // random limits read back; count is read-only
    repeat (4)
    begin
      v = $urandom;
      wr(ptc_pkg::OFF_LIMIT, v);
      rd(ptc_pkg::OFF_LIMIT, {24'h00_0000, v[7:0]});
      wr(ptc_pkg::OFF_COUNT, v);
      rd(ptc_pkg::OFF_COUNT, 32'h0000_0000);
    end
    repeat (2) @(posedge pclk);
    end_of_test();
  end
endmodule
